// ==== verilog/dfsr_pkg.sv ====
// shared constants and state types of the driver fault serial readout
package dfsr_pkg;

    // channel and fault layout
    localparam int NUM_CH = 4;
    localparam int FAULTS_PER_CH = 4;
    localparam int NUM_BITS = NUM_CH * FAULTS_PER_CH;
    localparam int KIND_OVERTEMP = 0;
    localparam int KIND_SUPPLY_SHORT = 1;
    localparam int KIND_GROUND_SHORT = 2;
    localparam int KIND_OPEN_LOAD = 3;

    // timing: filter delays in microseconds, system clock in MHz
    localparam int CLK_MHZ = 20;
    localparam int OPEN_GND_FILTER_US = 12;
    localparam int SUPPLY_SHORT_FILTER_US = 6;
    localparam int OPEN_GND_FILTER_CYC = OPEN_GND_FILTER_US * CLK_MHZ;
    localparam int SUPPLY_SHORT_FILTER_CYC = SUPPLY_SHORT_FILTER_US * CLK_MHZ;
    localparam int FILT_W = 8;
    localparam logic [FILT_W-1:0] OPEN_GND_FILTER_CNT = FILT_W'(OPEN_GND_FILTER_CYC);
    localparam logic [FILT_W-1:0] SUPPLY_SHORT_FILTER_CNT = FILT_W'(SUPPLY_SHORT_FILTER_CYC);

    // reset values
    localparam logic [NUM_BITS-1:0] FAULT_RST = 16'h0000;
    localparam logic [NUM_BITS-1:0] SHIFT_RST = 16'h0000;

    // positions inside the synchroniser vector
    localparam int SY_CS = 0;
    localparam int SY_SCLK = 1;
    localparam int SY_DI = 2;
    localparam int SY_EN = 3;
    localparam int SY_OT = 4;
    localparam int SY_OC = 8;
    localparam int SY_LO = 12;
    localparam int SY_MID = 16;
    localparam int SY_IN = 20;
    localparam int SY_LBIT = 24;
    localparam int SY_LSTART = 25;
    localparam int SY_W = 26;
    // synchronisers leave reset at idle pin levels: only select high, so no
    // false over-temperature or serial clock edge appears after reset
    localparam logic [SY_W-1:0] SYNC_RST = 26'h0000001;

    // serial position of a fault: bit 15 leaves first (channel 1 over-temperature)
    function automatic int dfsr_fidx(input int ch, input int kind);
        return NUM_BITS - 1 - (ch * FAULTS_PER_CH + kind);
    endfunction : dfsr_fidx

    typedef struct packed {
        logic [SY_W-1:0] sync1;
        logic [SY_W-1:0] sync2;
        logic cs_prev;
        logic sclk_prev;
        logic start_prev;
        logic [NUM_BITS-1:0] fault;
        logic [NUM_BITS-1:0] snap;
        logic err;
        logic gate;
        logic [NUM_CH-1:0] oc_latch;
        logic [NUM_CH-1:0] drive;
        logic [NUM_CH-1:0][FILT_W-1:0] oc_cnt;
        logic [NUM_CH-1:0][FILT_W-1:0] lo_cnt;
        logic [NUM_CH-1:0][FILT_W-1:0] mid_cnt;
        logic sdo_low;
    } dfsr_sys_s;

    typedef struct packed {
        logic started;
        logic out_bit;
        logic [NUM_BITS-1:0] sr;
    } dfsr_link_s;

endpackage : dfsr_pkg

// ==== verilog/dfsr_top.sv ====
// fault capture, filters and serial diagnostic readout of a quad low-side driver
//
// Summary of operation
// R1: chip select fall loads sixteen fault bits
// R2: host keeps serial clock low at select
// R3: rising edge shifts out, cascade bit enters
// R4: first rising edge clears parallel fault register
// R5: upstream data follows after sixteen clocks
// R6: new faults captured during shifting
// R7: summary bit is error flag OR cascade
// R8: error flag is OR of fault bits
// R9: first or lone device ties cascade low
// R10: output driven only while select low
// R11: pass-enable set by select fall, clock low
// R12: pass-enable survives select rise, clock low
// R13: clock high at select fall blocks cascade
// R14: first edge ends pass-enable, shows bit
// R15: error flag latched at each select fall
// R16: host holds select low whole chain
// R17: data follows clock polarity 0, phase 1
// R18: channel order one to four, fixed kinds
// R19: over-temperature gates channel, sets bit
// R20: filtered over-current latches channel off
// R21: off and low level sets ground short
// R22: off and mid level sets open load
// R23: open and ground faults need 12 us
module dfsr_top
    import dfsr_pkg::*;
(
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic cascade_serial_in_i,
    input wire logic sdo_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // channel control
    input wire logic enable_i,
    input wire logic [NUM_CH-1:0] chan_in_i,
    // sense comparators, one bit per channel
    input wire logic [NUM_CH-1:0] overtemp_sense_i,
    input wire logic [NUM_CH-1:0] overcurrent_sense_i,
    input wire logic [NUM_CH-1:0] below_gnd_thresh_i,
    input wire logic [NUM_CH-1:0] mid_supply_i,
    // status
    output logic [NUM_CH-1:0] chan_drive_o,
    output logic [NUM_BITS-1:0] fault_reg_o,
    output logic error_flag_o
);

    dfsr_sys_s sys_q;
    dfsr_sys_s sys_d;
    dfsr_link_s link_q;
    dfsr_link_s link_d;

    logic link_rst_n;
    logic cs_s;
    logic sclk_s;
    logic di_s;
    logic en_s;
    logic lbit_s;
    logic lstart_s;
    logic [NUM_CH-1:0] ot_s;
    logic [NUM_CH-1:0] oc_s;
    logic [NUM_CH-1:0] lo_s;
    logic [NUM_CH-1:0] mid_s;
    logic [NUM_CH-1:0] in_s;
    logic cs_fall;
    logic sclk_rise;
    logic clr;
    logic out_bit;
    logic [NUM_BITS-1:0] set_v;

    // link side: the frame's own select ends the shift state, so no
    // edge after the last one is needed; release is safe because the
    // host keeps the clock low while it lowers select
    assign link_rst_n = rst_n_i & ~cs_n_i; // R2

    always_comb begin
        link_d = link_q;
        link_d.started = 1'b1;
        if (!link_q.started) begin
            // snap is quiet for the whole frame; it is read only here
            link_d.out_bit = sys_q.snap[NUM_BITS-1]; // R14
            link_d.sr = {sys_q.snap[NUM_BITS-2:0], cascade_serial_in_i}; // R1
        end else begin
            link_d.out_bit = link_q.sr[NUM_BITS-1]; // R5
            link_d.sr = {link_q.sr[NUM_BITS-2:0], cascade_serial_in_i}; // R3
        end
    end

    // rising edge changes data, host samples on falling edge
    always_ff @(posedge sclk_i or negedge link_rst_n) begin // R17
        if (!link_rst_n) begin
            link_q <= '{started: 1'b0, out_bit: 1'b0, sr: SHIFT_RST};
        end else begin
            link_q <= link_d;
        end
    end

    // system side
    always_comb begin
        sys_d = sys_q;
        set_v = '0;
        sys_d.sync1 = {link_q.started, link_q.out_bit, chan_in_i, mid_supply_i,
                       below_gnd_thresh_i, overcurrent_sense_i, overtemp_sense_i,
                       enable_i, cascade_serial_in_i, sclk_i, cs_n_i};
        sys_d.sync2 = sys_q.sync1;
        cs_s = sys_q.sync2[SY_CS];
        sclk_s = sys_q.sync2[SY_SCLK];
        di_s = sys_q.sync2[SY_DI];
        en_s = sys_q.sync2[SY_EN];
        lbit_s = sys_q.sync2[SY_LBIT];
        lstart_s = sys_q.sync2[SY_LSTART];
        ot_s = sys_q.sync2[SY_OT +: NUM_CH];
        oc_s = sys_q.sync2[SY_OC +: NUM_CH];
        lo_s = sys_q.sync2[SY_LO +: NUM_CH];
        mid_s = sys_q.sync2[SY_MID +: NUM_CH];
        in_s = sys_q.sync2[SY_IN +: NUM_CH];

        cs_fall = sys_q.cs_prev & ~cs_s;
        sclk_rise = sclk_s & ~sys_q.sclk_prev;
        // link start flag rising marks the first serial clock edge
        clr = lstart_s & ~sys_q.start_prev; // R4
        sys_d.cs_prev = cs_s;
        sys_d.sclk_prev = sclk_s;
        sys_d.start_prev = lstart_s;

        for (int ch = 0; ch < NUM_CH; ch++) begin
            // supply short: filtered over-current latches the driver off
            if (en_s && oc_s[ch] && !sys_q.oc_latch[ch]) begin
                if (sys_q.oc_cnt[ch] != SUPPLY_SHORT_FILTER_CNT) begin
                    sys_d.oc_cnt[ch] = sys_q.oc_cnt[ch] + 8'h01;
                end
            end else begin
                sys_d.oc_cnt[ch] = '0;
            end
            // only the input going low re-arms the driver
            if (!in_s[ch]) begin
                sys_d.oc_latch[ch] = 1'b0; // R20
            end
            if (sys_q.oc_cnt[ch] == SUPPLY_SHORT_FILTER_CNT) begin
                sys_d.oc_latch[ch] = 1'b1; // R20
                set_v[dfsr_fidx(ch, KIND_SUPPLY_SHORT)] = 1'b1; // R20
            end
            // over-temperature gates the drive directly, no filter
            sys_d.drive[ch] = en_s & in_s[ch] & ~ot_s[ch] & ~sys_d.oc_latch[ch]; // R19
            set_v[dfsr_fidx(ch, KIND_OVERTEMP)] = ot_s[ch]; // R19

            // off-state checks, both through the long filter
            if (en_s && !sys_q.drive[ch] && lo_s[ch]) begin
                if (sys_q.lo_cnt[ch] != OPEN_GND_FILTER_CNT) begin
                    sys_d.lo_cnt[ch] = sys_q.lo_cnt[ch] + 8'h01; // R23
                end
            end else begin
                sys_d.lo_cnt[ch] = '0;
            end
            if (en_s && !sys_q.drive[ch] && mid_s[ch] && !lo_s[ch]) begin
                if (sys_q.mid_cnt[ch] != OPEN_GND_FILTER_CNT) begin
                    sys_d.mid_cnt[ch] = sys_q.mid_cnt[ch] + 8'h01; // R23
                end
            end else begin
                sys_d.mid_cnt[ch] = '0;
            end
            set_v[dfsr_fidx(ch, KIND_GROUND_SHORT)] =
                (sys_q.lo_cnt[ch] == OPEN_GND_FILTER_CNT); // R21
            set_v[dfsr_fidx(ch, KIND_OPEN_LOAD)] =
                (sys_q.mid_cnt[ch] == OPEN_GND_FILTER_CNT); // R22
        end

        // a fault seen in the clearing cycle survives the clear
        sys_d.fault = (sys_q.fault & ~{NUM_BITS{clr}}) | set_v; // R6 R18

        if (cs_fall) begin
            sys_d.snap = sys_q.fault; // R1
            sys_d.err = |sys_q.fault; // R8 R15
        end

        // pass-enable ignores select rising; a clock edge, or a select fall with clock high, drops it
        if (cs_fall) begin
            sys_d.gate = ~sclk_s; // R11 R13
        end else if (sclk_rise) begin
            sys_d.gate = 1'b0; // R12 R14
        end

        if (cs_s) begin
            out_bit = 1'b1;
        end else if (sys_d.gate) begin
            out_bit = sys_d.err | di_s; // R7 R11
        end else if (lstart_s) begin
            out_bit = lbit_s; // R14
        end else begin
            out_bit = sys_d.err; // R7 R13
        end
        // open drain: pull low only for a zero and only while selected
        sys_d.sdo_low = ~cs_s & ~out_bit; // R10
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_q <= '{sync1: SYNC_RST, sync2: SYNC_RST, cs_prev: 1'b1,
                       sclk_prev: 1'b0, start_prev: 1'b0, fault: FAULT_RST,
                       snap: FAULT_RST, err: 1'b0, gate: 1'b0, oc_latch: '0,
                       drive: '0, oc_cnt: '0, lo_cnt: '0, mid_cnt: '0,
                       sdo_low: 1'b0};
        end else begin
            sys_q <= sys_d;
        end
    end

    // the pin level itself is not needed; the driver never reads back
    assign sdo_o = 1'b0;
    assign sdo_oe_o = sys_q.sdo_low;
    assign chan_drive_o = sys_q.drive;
    assign fault_reg_o = sys_q.fault;
    assign error_flag_o = sys_q.err;

endmodule : dfsr_top

// ==== sim/dfsr_top_assertions.sv ====
// port checks of the fault readout
module dfsr_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic cascade_serial_in_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic [3:0] overtemp_sense_i,
    input wire logic [3:0] below_gnd_thresh_i,
    input wire logic [3:0] mid_supply_i,
    input wire logic [3:0] chan_drive_o,
    input wire logic [15:0] fault_reg_o,
    input wire logic error_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire quiet = !(|{overtemp_sense_i, below_gnd_thresh_i, mid_supply_i});
    AST_OE_IDLE: assert property (cs_n_i [*6] |-> !sdo_oe_o)
        else $error("data pin driven while deselected");
    AST_OD_LOW: assert property (sdo_oe_o |-> !sdo_o && !($past(cs_n_i, 2) && $past(cs_n_i, 3)))
        else $error("data pulled low without select");
    AST_SUM: assert property ($fell(cs_n_i) ##1 (!cs_n_i && !sclk_i) [*5]
        |-> sdo_oe_o == !(error_flag_o | cascade_serial_in_i)) else $error("summary wrong");
    AST_GATE_OFF: assert property (($fell(cs_n_i) && sclk_i) ##1 (!cs_n_i && sclk_i) [*5]
        |-> sdo_oe_o == !error_flag_o) else $error("cascade passed");
    AST_ERR: assert property ($changed(error_flag_o) |->
        !cs_n_i && error_flag_o == $past(|fault_reg_o)) else $error("error flag wrong");
    AST_CLR: assert property ($rose(sclk_i) && !cs_n_i && quiet
        |-> ##[1:6] fault_reg_o == 16'h0000) else $error("faults not cleared");
    AST_OT: assert property (overtemp_sense_i[0] [*4]
        |=> fault_reg_o[15] && !chan_drive_o[0]) else $error("overtemp not handled");
    AST_OT_SRC: assert property ($rose(fault_reg_o[15])
        |-> $past(overtemp_sense_i[0], 3)) else $error("overtemp bit without cause");
    cover property ($fell(cs_n_i) && !sclk_i);
    cover property ($fell(cs_n_i) && sclk_i);
    cover property ($rose(error_flag_o));
    cover property ($rose(fault_reg_o[14]));
endmodule : dfsr_chk

bind dfsr_top dfsr_chk dfsr_chk_i (.*);

// ==== sim/dfsr_host.sv ====
// serial host model reading the fault chain
module dfsr_host (
    input wire logic line_i,
    output logic sclk_o,
    output logic cs_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic grid = 1'h0;
    initial begin
        {sclk_o, cs_n_o} = 2'h1;
        #7;
        forever #24 grid = ~grid;
    end
    // six 48 ns steps a level: data settles up to 150 ns after a rise
    task automatic frame(input int nbits, input logic hi, output logic sum,
        output logic [31:0] bits);
        bits = '0;
        @(posedge grid) sclk_o = hi;
        @(posedge grid) cs_n_o = 1'h0;
        repeat (7) @(posedge grid);
        sum = line_i;
        for (int k = 0; k < nbits; k++) begin
            sclk_o = 1'h1;
            repeat (6) @(posedge grid);
            bits = {bits[30:0], line_i};
            sclk_o = 1'h0;
            repeat (6) @(posedge grid);
        end
        cs_n_o = 1'h1;
        @(posedge grid) sclk_o = 1'h0;
    endtask : frame
endmodule : dfsr_host

// ==== sim/tb.sv ====
// randomised bench of the fault readout
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic di, en, sdo, oe, err, line, sclk, cs_n, sum;
    logic [3:0] cin, ot, lo, mid, drv, oc;
    logic [15:0] freg, want;
    logic [31:0] rx;
    int fails = 0;
    int samples_checked = 0;
    assign line = oe ? sdo : 1'h1;
    dfsr_host dfsr_host_i (.line_i(line), .sclk_o(sclk), .cs_n_o(cs_n));
    dfsr_top dfsr_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .cascade_serial_in_i(di), .sdo_i(line), .sdo_o(sdo), .sdo_oe_o(oe), .enable_i(en),
        .chan_in_i(cin), .overtemp_sense_i(ot), .overcurrent_sense_i(oc),
        .below_gnd_thresh_i(lo), .mid_supply_i(mid), .chan_drive_o(drv),
        .fault_reg_o(freg), .error_flag_o(err));
    initial forever #25 clk_i = ~clk_i;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, want, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    function automatic logic [15:0] faults(input logic [3:0] t, l, m);
        logic [15:0] w;
        w = 16'h0000;
        for (int c = 0; c < 4; c++) begin
            w[15-4*c] = t[c];
            w[13-4*c] = l[c];
            w[12-4*c] = m[c] & ~l[c];
        end
        return w;
    endfunction : faults
    initial begin
        {di, en, cin, ot, lo, mid, oc} = '0;
        void'($urandom(91893));
        tick(6);
        rst_n_i = 1'h1;
        tick(4);
        en = 1'h1;
        for (int n = 0; n < 6; n++) begin
            // corners: no fault at all, then every over-temperature and ground short at once
            {ot, lo, mid} = (n == 0) ? 12'h000 : (n == 5) ? 12'hFFF : 12'($urandom);
            cin = ~(lo | mid);
            di = (n < 2) ? 1'h0 : 1'(n % 2);
            want = faults(ot, lo, mid) | ((n > 0) ? 16'h0008 : 16'h0000);
            tick(200);
            check("filter_early", 32'(freg & 16'h3333), 32'h0);
            tick(100);
            check("drive", 32'(drv), 32'(cin & ~ot));
            {ot, lo, mid} = '0;
            tick(5);
            check("fault_reg", 32'(freg), 32'(want));
            fork
                dfsr_host_i.frame(32, 1'h0, sum, rx);
                begin
                    tick(40);
                    ot = 4'h8;
                end
            join
            check("summary", 32'(sum), 32'((|want) | di));
            check("own_bits", 32'(rx[31:16]), 32'(want));
            check("cascade_bits", 32'(rx[15:0]), 32'({16{di}}));
            tick(5);
            check("after_read", 32'(freg), 32'h0008);
            check("err_latched", 32'(err), 32'(|want));
            ot = 4'h0;
            $display("test %0d done", n);
        end
        // supply short on channel 1 latches its driver off until the input toggles
        cin = 4'hF;
        oc = 4'h1;
        tick(130);
        check("short_bit", 32'(freg), 32'h00004008);
        check("short_drive", 32'(drv), 32'h0000000E);
        oc = 4'h0;
        tick(5);
        check("short_latched", 32'(drv), 32'h0000000E);
        cin = 4'hE;
        tick(5);
        cin = 4'hF;
        tick(5);
        check("short_rearm", 32'(drv), 32'h0000000F);
        $display("test supply_short done");
        di = 1'h1;
        dfsr_host_i.frame(16, 1'h0, sum, rx);
        tick(5);
        dfsr_host_i.frame(0, 1'h1, sum, rx);
        check("gate_off", 32'(sum), 32'h0);
        $display("test gate_off done");
        finish_test();
    end
endmodule : tb
